// file: src/ccs_pkg.sv
// Purpose: Shared constants for the clock source select and HF oscillator block
// Assumes: Special function register addresses are eight bits wide
// Notes: Trim reset value is a stand-in for the per-part trimmed value
package ccs_pkg;

  // Register addresses on the special function register port
  localparam logic [7:0] SFR_CLOCK_SOURCE_SELECT = 8'hA9;
  localparam logic [7:0] SFR_HF_OSC_CONTROL = 8'hB2;
  localparam logic [7:0] SFR_HF_OSC_TRIM = 8'hB3;

  // Clock source select field positions
  localparam int USB_FIELD_LSB = 4;
  localparam int OUT_SYNC_BIT = 3;
  localparam int SYS_FIELD_LSB = 0;

  // HF oscillator control field positions
  localparam int HFC_ENABLE_BIT = 7;
  localparam int HFC_READY_BIT = 6;
  localparam int HFC_SUSPEND_BIT = 5;
  localparam int HFC_DIV_LSB = 0;

  // Values after reset
  localparam logic [6:0] CLOCK_SELECT_RESET = 7'h00;
  localparam logic HF_ENABLE_RESET = 1'h1;
  localparam logic [1:0] HF_DIVIDER_RESET = 2'h0;
  // Arbitrary stand-in for the trimmed 48 MHz setting
  localparam logic [6:0] HF_TRIM_RESET = 7'h40;

  // System clock source codes
  localparam logic [2:0] SYS_HF_SCALED = 3'h0;
  localparam logic [2:0] SYS_EXT = 3'h1;
  localparam logic [2:0] SYS_HF_HALF = 3'h2;
  localparam logic [2:0] SYS_HF = 3'h3;
  localparam logic [2:0] SYS_LF_SCALED = 3'h4;

  // USB clock source codes
  localparam logic [2:0] USB_HF = 3'h0;
  localparam logic [2:0] USB_HF_DIV8 = 3'h1;
  localparam logic [2:0] USB_EXT = 3'h2;
  localparam logic [2:0] USB_EXT_DIV2 = 3'h3;
  localparam logic [2:0] USB_EXT_DIV3 = 3'h4;
  localparam logic [2:0] USB_EXT_DIV4 = 3'h5;
  localparam logic [2:0] USB_LF = 3'h6;
  localparam logic [2:0] USB_RESERVED = 3'h7;

  // Divider chain and synchroniser widths
  localparam int HF_CNT_W = 5;
  localparam int EXT_CNT_W = 2;
  localparam int LF_CNT_W = 3;
  localparam int SYNC_W = 7;

endpackage : ccs_pkg

// file: src/ccs_glitch_mux.sv
// Purpose: Glitch-free selection of one clock level out of eight candidates
// Assumes: Candidates are flop levels on clk; unused candidates are tied low
// Notes: Parks low between sources so no runt pulse is ever produced
module ccs_glitch_mux (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rstN,
  input wire logic ce,
  // Selection
  input wire logic [2:0] reqSel,
  input wire logic [7:0] srcVec,
  // Result
  output logic clock_out_sync_select_q,
  output logic [2:0] curSel_q
);

  typedef enum logic {CCS_RUN, CCS_PARK} ccs_mux_e;
  ccs_mux_e state_q;

  // Leave the old source only in its low phase, join the new one only in its low phase
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_q <= CCS_RUN;
      curSel_q <= 3'h0;
      clock_out_sync_select_q <= 1'b0;
    end else if (ce) begin
      unique case (state_q)
        CCS_RUN: begin
          if (reqSel != curSel_q && !srcVec[curSel_q]) begin
            state_q <= CCS_PARK;
            clock_out_sync_select_q <= 1'b0;
          end else begin
            clock_out_sync_select_q <= srcVec[curSel_q];
          end
        end
        CCS_PARK: begin
          clock_out_sync_select_q <= 1'b0;
          if (!srcVec[reqSel]) begin
            curSel_q <= reqSel;
            state_q <= CCS_RUN;
          end
        end
      endcase
    end
  end

  // A selection change only ever happens with the output low
  a_switch_when_low: assert property (@(posedge clk) disable iff (!rstN || !ce)
    $changed(curSel_q) |-> !clock_out_sync_select_q && $past(state_q) == CCS_PARK)
    else $error("clock source changed while output high");

  // Settled output tracks the chosen candidate one cycle later
  a_follow_source: assert property (@(posedge clk) disable iff (!rstN || !ce)
    (state_q == CCS_RUN && reqSel == curSel_q) |=> clock_out_sync_select_q == $past(srcVec[curSel_q]))
    else $error("clock output does not follow selected source");

endmodule : ccs_glitch_mux

// file: src/ccs_clock_select.sv
// Purpose: System and USB clock source selection with HF oscillator control and trim
// Assumes: Oscillator levels and wake events are asynchronous and are sampled on core_clk
// Notes: Register reads answer one cycle after the read strobe
//
// Functional notes
// - USB clock codes 000 HF, 001 HF divided by 8, 010 external.
// - USB codes 011/100/101 external by 2/3/4, 110 LF, 111 reserved.
// - Top bit of clock select reads zero; writes to it ignored.
// - Clock-out bit 3 picks raw or port-resynchronised core clock.
// - System code 000 is scaled HF, 001 the external oscillator.
// - System code 010 HF by 2, 011 HF undivided, 100 scaled LF.
// - Clock select resets to zero, so HF drives the core clock.
// - HF passes fixed divide by 4, then 1/2/4/8; resets to 8.
// - Writing suspend stops the HF oscillator and halts an HF core clock.
// - Port 0 match, port 1 match, timer overflow, USB resume wake it.
// - Wake resumes everything whether or not an interrupt follows.
// - Seven-bit trim sets HF period; zeros fastest, ones slowest.
// - Trim resets to the trimmed value; its top bit reads zero.
// - Divider field 00 by 8, 01 by 4, 10 by 2, 11 by 1.
module ccs_clock_select (
  // Clock, reset, enable
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic ce,
  // Special function register port
  input wire logic [7:0] sfrAddr,
  input wire logic [7:0] sfrWrData,
  input wire logic sfrWrEn,
  input wire logic sfrRdEn,
  output logic [7:0] sfrRdData_q,
  // Oscillator levels
  input wire logic hfOscIn,
  input wire logic lfOscIn,
  input wire logic extOscIn,
  // LF divider setting from the LF oscillator control logic
  input wire logic [1:0] lfDividerSel,
  // Wake events
  input wire logic wakePort0Match,
  input wire logic wakePort1Match,
  input wire logic wakeTimerOverflow,
  input wire logic wakeUsbResume,
  // Clock and oscillator outputs
  output logic coreClock,
  output logic usbClock,
  output logic clockPinOut_q,
  output logic hfOscEnable_q,
  output logic [6:0] hfTrim_q
);

  logic rstMeta_q;
  logic rstSync_q;
  logic [ccs_pkg::SYNC_W-1:0] inMeta_q;
  logic [ccs_pkg::SYNC_W-1:0] inSync_q;
  logic [2:0] oscPrev_q;
  logic [2:0] usbField_q;
  logic clockOutSync_q;
  logic [2:0] sysField_q;
  logic hfEnable_q;
  logic suspend_q;
  logic [1:0] hfDivider_q;
  logic hfReady_q;
  logic [ccs_pkg::HF_CNT_W-1:0] hfCnt_q;
  logic [ccs_pkg::EXT_CNT_W-1:0] extCnt_q;
  logic [1:0] extMod3_q;
  logic [ccs_pkg::LF_CNT_W-1:0] lfCnt_q;
  logic pinStage_q;
  logic hfLevel;
  logic extLevel;
  logic lfLevel;
  logic anyWake;
  logic hfScaled;
  logic lfScaled;
  logic [7:0] sysSrc;
  logic [7:0] usbSrc;
  logic [2:0] sysCur;
  logic [2:0] usbCur;
  logic wrSelect;
  logic wrControl;
  logic wrTrim;

  // Reset released through two flops, asserted at once
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_q <= 1'b0;
      rstSync_q <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_q <= rstMeta_q;
    end
  end

  // Two-flop synchronisers for oscillators and wake events
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      inMeta_q <= '0;
      inSync_q <= '0;
    end else if (ce) begin
      inMeta_q <= {wakeUsbResume, wakeTimerOverflow, wakePort1Match, wakePort0Match, extOscIn, lfOscIn, hfOscIn};
      inSync_q <= inMeta_q;
    end
  end

  // HF level is forced low while disabled or suspended, so its chain freezes
  assign hfLevel = inSync_q[0] & hfEnable_q & ~suspend_q;
  assign lfLevel = inSync_q[1];
  assign extLevel = inSync_q[2];
  assign anyWake = |inSync_q[6:3];

  // Register strobes
  assign wrSelect = sfrWrEn && sfrAddr == ccs_pkg::SFR_CLOCK_SOURCE_SELECT;
  assign wrControl = sfrWrEn && sfrAddr == ccs_pkg::SFR_HF_OSC_CONTROL;
  assign wrTrim = sfrWrEn && sfrAddr == ccs_pkg::SFR_HF_OSC_TRIM;

  // Clock source select; bit 7 has no storage
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      {usbField_q, clockOutSync_q, sysField_q} <= ccs_pkg::CLOCK_SELECT_RESET;
    end else if (ce && wrSelect) begin
      usbField_q <= sfrWrData[ccs_pkg::USB_FIELD_LSB +: 3];
      clockOutSync_q <= sfrWrData[ccs_pkg::OUT_SYNC_BIT];
      sysField_q <= sfrWrData[ccs_pkg::SYS_FIELD_LSB +: 3];
    end
  end

  // HF control; a wake beats a suspend written in the same cycle so the core never hangs
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      hfEnable_q <= ccs_pkg::HF_ENABLE_RESET;
      suspend_q <= 1'b0;
      hfDivider_q <= ccs_pkg::HF_DIVIDER_RESET;
    end else if (ce) begin
      if (wrControl) begin
        hfEnable_q <= sfrWrData[ccs_pkg::HFC_ENABLE_BIT];
        hfDivider_q <= sfrWrData[ccs_pkg::HFC_DIV_LSB +: 2];
      end
      if (anyWake) begin
        suspend_q <= 1'b0;
      end else if (wrControl) begin
        suspend_q <= sfrWrData[ccs_pkg::HFC_SUSPEND_BIT];
      end
    end
  end

  // Trim register drives the oscillator period directly
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      hfTrim_q <= ccs_pkg::HF_TRIM_RESET;
    end else if (ce && wrTrim) begin
      hfTrim_q <= sfrWrData[6:0];
    end
  end

  // Oscillator enable pin and ready flag
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      hfOscEnable_q <= 1'b0;
      hfReady_q <= 1'b0;
      oscPrev_q <= '0;
    end else if (ce) begin
      hfOscEnable_q <= hfEnable_q & ~suspend_q;
      oscPrev_q <= {extLevel, lfLevel, hfLevel};
      if (!(hfEnable_q && !suspend_q)) begin
        hfReady_q <= 1'b0;
      end else if (hfLevel && !oscPrev_q[0]) begin
        hfReady_q <= 1'b1;
      end
    end
  end

  // Ripple-free divider chains, stepped on sampled rising edges
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      hfCnt_q <= '0;
      extCnt_q <= '0;
      extMod3_q <= 2'h0;
      lfCnt_q <= '0;
    end else if (ce) begin
      if (hfLevel && !oscPrev_q[0]) begin
        hfCnt_q <= hfCnt_q + 1'b1;
      end
      if (lfLevel && !oscPrev_q[1]) begin
        lfCnt_q <= lfCnt_q + 1'b1;
      end
      if (extLevel && !oscPrev_q[2]) begin
        extCnt_q <= extCnt_q + 1'b1;
        extMod3_q <= (extMod3_q == 2'h2) ? 2'h0 : extMod3_q + 2'h1;
      end
    end
  end

  // HF counter bit 1 is the fixed divide by 4; higher bits add 2, 4, 8
  always_comb begin
    unique case (hfDivider_q)
      2'h0: hfScaled = hfCnt_q[4];
      2'h1: hfScaled = hfCnt_q[3];
      2'h2: hfScaled = hfCnt_q[2];
      2'h3: hfScaled = hfCnt_q[1];
    endcase
  end

  // LF post-scaler by 1, 2, 4 or 8
  always_comb begin
    unique case (lfDividerSel)
      2'h0: lfScaled = lfLevel;
      2'h1: lfScaled = lfCnt_q[0];
      2'h2: lfScaled = lfCnt_q[1];
      2'h3: lfScaled = lfCnt_q[2];
    endcase
  end

  // Candidate sets indexed by field code; undefined codes are tied low
  always_comb begin
    sysSrc = 8'h00;
    sysSrc[ccs_pkg::SYS_HF_SCALED] = hfScaled;
    sysSrc[ccs_pkg::SYS_EXT] = extLevel;
    sysSrc[ccs_pkg::SYS_HF_HALF] = hfCnt_q[0];
    sysSrc[ccs_pkg::SYS_HF] = hfLevel;
    sysSrc[ccs_pkg::SYS_LF_SCALED] = lfScaled;
    usbSrc = 8'h00;
    usbSrc[ccs_pkg::USB_HF] = hfLevel;
    usbSrc[ccs_pkg::USB_HF_DIV8] = hfCnt_q[2];
    usbSrc[ccs_pkg::USB_EXT] = extLevel;
    usbSrc[ccs_pkg::USB_EXT_DIV2] = extCnt_q[0];
    usbSrc[ccs_pkg::USB_EXT_DIV3] = (extMod3_q == 2'h0);
    usbSrc[ccs_pkg::USB_EXT_DIV4] = extCnt_q[1];
    usbSrc[ccs_pkg::USB_LF] = lfLevel;
  end

  // Software must pick a running source, otherwise the mux holds its output low until a running source is picked
  ccs_glitch_mux u_sys_mux (
    .clk(core_clk),
    .rstN(rstSync_q),
    .ce(ce),
    .reqSel(sysField_q),
    .srcVec(sysSrc),
    .clock_out_sync_select_q(coreClock),
    .curSel_q(sysCur)
  );

  ccs_glitch_mux u_usb_mux (
    .clk(core_clk),
    .rstN(rstSync_q),
    .ce(ce),
    .reqSel(usbField_q),
    .srcVec(usbSrc),
    .clock_out_sync_select_q(usbClock),
    .curSel_q(usbCur)
  );

  // Clock-out pin: raw form one flop late, port-synchronised form one stage later
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      pinStage_q <= 1'b0;
      clockPinOut_q <= 1'b0;
    end else if (ce) begin
      pinStage_q <= coreClock;
      clockPinOut_q <= clockOutSync_q ? pinStage_q : coreClock;
    end
  end

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge core_clk or negedge rstSync_q) begin
    if (!rstSync_q) begin
      sfrRdData_q <= 8'h00;
    end else if (ce && sfrRdEn) begin
      unique case (sfrAddr)
        ccs_pkg::SFR_CLOCK_SOURCE_SELECT: sfrRdData_q <= {1'b0, usbField_q, clockOutSync_q, sysField_q};
        ccs_pkg::SFR_HF_OSC_CONTROL: sfrRdData_q <= {hfEnable_q, hfReady_q, suspend_q, 3'h0, hfDivider_q};
        ccs_pkg::SFR_HF_OSC_TRIM: sfrRdData_q <= {1'b0, hfTrim_q};
        default: sfrRdData_q <= 8'h00;
      endcase
    end
  end

  a_select_top_zero: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (sfrRdEn && sfrAddr == ccs_pkg::SFR_CLOCK_SOURCE_SELECT) |=> !sfrRdData_q[7])
    else $error("clock select bit 7 read as one");

  a_trim_readback: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (wrTrim && !sfrRdEn) ##1 (sfrRdEn && sfrAddr == ccs_pkg::SFR_HF_OSC_TRIM && !wrTrim)
      |=> sfrRdData_q == {1'b0, $past(sfrWrData[6:0], 2)})
    else $error("trim read back wrong");

  a_reset_defaults: assert property (@(posedge core_clk) disable iff (!ce)
    $rose(rstSync_q) |-> sysField_q == 3'h0 && usbField_q == 3'h0 && hfDivider_q == 2'h0
      && hfTrim_q == ccs_pkg::HF_TRIM_RESET)
    else $error("wrong values after reset");

  a_wake_clears: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (suspend_q && anyWake) |=> !suspend_q ##1 hfOscEnable_q == hfEnable_q)
    else $error("wake event did not end suspend");

  a_suspend_stops: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (wrControl && sfrWrData[ccs_pkg::HFC_SUSPEND_BIT] && !anyWake) ##1 !anyWake |=> !hfOscEnable_q)
    else $error("oscillator still enabled in suspend");

  a_core_halts: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (suspend_q && sysCur == ccs_pkg::SYS_HF && sysField_q == sysCur)[*3] |-> $stable(coreClock))
    else $error("core clock toggled during suspend");

  a_usb_reserved: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (usbCur == ccs_pkg::USB_RESERVED && usbField_q == usbCur)[*2] |-> !usbClock)
    else $error("reserved USB code produced a clock");

  a_pin_raw: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    !clockOutSync_q |=> clockPinOut_q == $past(coreClock))
    else $error("raw clock-out does not follow core clock");

  a_pin_sync: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    clockOutSync_q |=> clockPinOut_q == $past(coreClock, 2))
    else $error("synchronised clock-out has wrong delay");

  a_div_reset: assert property (@(posedge core_clk) disable iff (!rstSync_q || !ce)
    (hfDivider_q == 2'h0 && sysCur == ccs_pkg::SYS_HF_SCALED && sysField_q == sysCur) |=> coreClock == $past(hfCnt_q[4]))
    else $error("default HF scaling is not divide by 32");

endmodule : ccs_clock_select

// file: tb/clock_source_select_and_hf_osc_tb_top.sv
// Purpose: Self-checking bench for clock source selection, HF divider, trim and suspend
// Assumes: Oscillators are slow square waves made on core_clk; outputs are levels on core_clk
// Notes: Periods are measured in core_clk cycles and compared with a small integer model
module clock_source_select_and_hf_osc_tb_top;
  timeunit 1ns;
  timeprecision 100ps;

  // Oscillator half periods in core cycles
  localparam int HH = 3;
  localparam int EH = 2;
  localparam int LH = 5;

  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic ce = 1'b1;
  logic [7:0] sfrAddr = 8'h00;
  logic [7:0] sfrWrData = 8'h00;
  logic sfrWrEn = 1'b0;
  logic sfrRdEn = 1'b0;
  logic [7:0] sfrRdData_q;
  logic hfOscIn = 1'b0;
  logic lfOscIn = 1'b0;
  logic extOscIn = 1'b0;
  logic [1:0] lfDividerSel = 2'h0;
  logic [3:0] wake = 4'h0;
  logic coreClock, usbClock, clockPinOut_q, hfOscEnable_q;
  logic [6:0] hfTrim_q;
  int miscompares = 0;
  int cmpCount = 0;
  int oscCnt = 0;
  int mA9, mB2, per, i, d;
  logic [7:0] rv, rnd;
  logic coreHist[$];
  logic pinHist[$];

  ccs_clock_select uut (
    .core_clk(core_clk), .rst_b(rst_b), .ce(ce),
    .sfrAddr(sfrAddr), .sfrWrData(sfrWrData), .sfrWrEn(sfrWrEn), .sfrRdEn(sfrRdEn),
    .sfrRdData_q(sfrRdData_q), .hfOscIn(hfOscIn), .lfOscIn(lfOscIn), .extOscIn(extOscIn),
    .lfDividerSel(lfDividerSel), .wakePort0Match(wake[0]), .wakePort1Match(wake[1]),
    .wakeTimerOverflow(wake[2]), .wakeUsbResume(wake[3]), .coreClock(coreClock),
    .usbClock(usbClock), .clockPinOut_q(clockPinOut_q), .hfOscEnable_q(hfOscEnable_q),
    .hfTrim_q(hfTrim_q)
  );

  // Clock at 100 MHz
  always #5 core_clk = ~core_clk;

  // Free-running oscillators, changed just after the core edge
  always @(posedge core_clk) begin
    #1;
    oscCnt <= oscCnt + 1;
    if (oscCnt % HH == 0) hfOscIn <= ~hfOscIn;
    if (oscCnt % EH == 0) extOscIn <= ~extOscIn;
    if (oscCnt % LH == 0) lfOscIn <= ~lfOscIn;
  end

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge core_clk);
    #1;
    sfrAddr = a;
    sfrWrData = v;
    sfrWrEn = 1'b1;
    @(posedge core_clk);
    #1;
    sfrWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge core_clk);
    #1;
    sfrAddr = a;
    sfrRdEn = 1'b1;
    @(posedge core_clk);
    #1;
    sfrRdEn = 1'b0;
    v = sfrRdData_q;
  endtask : rd

  // Write, then read the same register in the very next cycle
  task automatic wrRd(input logic [7:0] a, input logic [7:0] v, output logic [7:0] r);
    @(posedge core_clk);
    #1;
    sfrAddr = a;
    sfrWrData = v;
    sfrWrEn = 1'b1;
    @(posedge core_clk);
    #1;
    sfrWrEn = 1'b0;
    sfrRdEn = 1'b1;
    @(posedge core_clk);
    #1;
    sfrRdEn = 1'b0;
    r = sfrRdData_q;
  endtask : wrRd

  // Time between the second and third rising edge; zero if the clock stands still
  task automatic meas(input int which, input int lim, output int p);
    int t, r;
    int tm[3];
    logic prev, cur;
    p = 0;
    r = 0;
    prev = 1'b1;
    for (t = 0; t < lim && r < 3; t++) begin
      @(posedge core_clk);
      #1;
      cur = (which == 0) ? coreClock : usbClock;
      if (cur === 1'b1 && prev === 1'b0) begin
        tm[r] = t;
        r++;
      end
      prev = cur;
    end
    if (r == 3) p = tm[2] - tm[1];
  endtask : meas

  // Model of the expected system and USB clock periods
  function automatic int sysPer(input int c, input int dv, input int ld);
    case (c)
      0: return 2 * HH * 4 * (8 >> dv);
      1: return 2 * EH;
      2: return 4 * HH;
      3: return 2 * HH;
      4: return (2 * LH) << ld;
      default: return 0;
    endcase
  endfunction : sysPer

  function automatic int usbPer(input int c);
    case (c)
      0: return 2 * HH;
      1: return 16 * HH;
      2: return 2 * EH;
      3: return 4 * EH;
      4: return 6 * EH;
      5: return 8 * EH;
      6: return 2 * LH;
      default: return 0;
    endcase
  endfunction : usbPer

  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmpCount, miscompares);
    if (miscompares == 0 && cmpCount > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_sim

  // Watchdog sized well above the expected run of about 5k cycles
  initial begin
    #(100000 * 10);
    miscompares++;
    end_sim();
  end

  initial begin
    void'($urandom(11));
    repeat (10) @(posedge core_clk);
    #1;
    rst_b = 1'b1;
    repeat (5) @(posedge core_clk);
    // Reset values and reset clock source
    mA9 = 0;
    mB2 = 8'h80;
    rd(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, rv);
    chk("select reset", rv, mA9);
    rd(ccs_pkg::SFR_HF_OSC_CONTROL, rv);
    chk("control reset", rv & 8'hBF, mB2);
    rd(ccs_pkg::SFR_HF_OSC_TRIM, rv);
    chk("trim reset", rv, {1'b0, ccs_pkg::HF_TRIM_RESET});
    meas(0, 1000, per);
    chk("reset core period", per, sysPer(0, 0, 0));
    $display("test reset done");
    // Read-only top bits, unmapped address, random writes
    for (i = 0; i < 4; i++) begin
      rnd = 8'($urandom) | 8'h80;
      wrRd(ccs_pkg::SFR_HF_OSC_TRIM, rnd, rv);
      chk("trim read", rv, rnd & 8'h7F);
      chk("trim out", hfTrim_q, rnd[6:0]);
      wrRd(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, rnd, rv);
      chk("select read", rv, rnd & 8'h7F);
    end
    wr(ccs_pkg::SFR_HF_OSC_TRIM, 8'h00);
    chk("trim fastest", hfTrim_q, 7'h00);
    wr(ccs_pkg::SFR_HF_OSC_TRIM, 8'hFF);
    chk("trim slowest", hfTrim_q, 7'h7F);
    wr(8'hA8, 8'h55);
    rd(8'hA8, rv);
    chk("unmapped read", rv, 8'h00);
    // Clock enable low freezes every flop but the reset synchroniser, strobes and clock levels included
    ce = 1'b0;
    rnd = {6'h00, usbClock, coreClock};
    wr(ccs_pkg::SFR_HF_OSC_TRIM, 8'h15);
    rd(ccs_pkg::SFR_HF_OSC_TRIM, rv);
    chk("ce write ignored", hfTrim_q, 7'h7F);
    chk("ce read held", rv, 8'h00);
    repeat (8) begin
      @(posedge core_clk);
      #1;
      chk("ce frozen", {usbClock, coreClock}, rnd[1:0]);
    end
    ce = 1'b1;
    $display("test registers done");
    // Divider field, unused bits ignored
    wr(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, 8'h00);
    for (d = 0; d < 4; d++) begin
      wr(ccs_pkg::SFR_HF_OSC_CONTROL, 8'h9C | d[7:0]);
      rd(ccs_pkg::SFR_HF_OSC_CONTROL, rv);
      chk("divider read", rv & 8'hBF, 8'h80 | d);
      meas(0, 1000, per);
      chk("scaled hf period", per, sysPer(0, d, 0));
    end
    $display("test divider done");
    // System sources, LF post-scaler through all settings
    for (i = 1; i < 6; i++) begin
      for (d = 0; d < ((i == 4) ? 4 : 1); d++) begin
        lfDividerSel = d[1:0];
        wr(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, i[7:0]);
        meas(0, 1000, per);
        chk("core period", per, sysPer(i, 3, d));
      end
    end
    $display("test system sources done");
    // Every USB source code, reserved code stays still
    for (i = 0; i < 8; i++) begin
      wr(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, 8'(i << 4) | 8'h03);
      meas(1, 600, per);
      chk("usb period", per, usbPer(i));
    end
    $display("test usb sources done");
    // Clock-out pin is core clock delayed one or two cycles
    for (i = 0; i < 2; i++) begin
      wr(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, 8'h03 | 8'(i << 3));
      repeat (4) @(posedge core_clk);
      coreHist.delete();
      pinHist.delete();
      repeat (30) begin
        @(posedge core_clk);
        #2;
        coreHist.push_back(coreClock);
        pinHist.push_back(clockPinOut_q);
      end
      for (d = 2; d < 30; d++) chk("clock out", pinHist[d], coreHist[d - 1 - i]);
    end
    $display("test clock out done");
    // Suspend halts the HF core clock; each wake event restarts it
    wr(ccs_pkg::SFR_CLOCK_SOURCE_SELECT, 8'h03);
    for (i = 0; i < 4; i++) begin
      wr(ccs_pkg::SFR_HF_OSC_CONTROL, 8'hA3);
      repeat (3) @(posedge core_clk);
      #1;
      chk("osc stopped", hfOscEnable_q, 1'b0);
      meas(0, 120, per);
      chk("core halted", per, 0);
      @(posedge core_clk);
      #1;
      wake[i] = 1'b1;
      repeat (3) @(posedge core_clk);
      #1;
      wake[i] = 1'b0;
      repeat (3) @(posedge core_clk);
      #1;
      chk("osc resumed", hfOscEnable_q, 1'b1);
      rd(ccs_pkg::SFR_HF_OSC_CONTROL, rv);
      chk("suspend cleared", rv & 8'hBF, 8'h83);
      meas(0, 200, per);
      chk("core resumed", per, sysPer(3, 3, 0));
    end
    $display("test suspend done");
    end_sim();
  end
endmodule : clock_source_select_and_hf_osc_tb_top
